// ==== hdl/fcb_pkg.sv ====
// Shared constants and types of the flash configuration boot manager
package fcb_pkg;
  // ****************************************
  // Selector and addressing
  // ****************************************
  localparam int          SEL_W          = 3;
  localparam int          MODE_BIT       = 2;
  localparam int          SEG_W          = 2;
  localparam logic        MODE_PROGRAM   = 1'b1;
  localparam int          BYTE_W         = 8;
  localparam int          SECT_W         = 10;
  localparam int          OFFS_W         = 8;
  localparam int          ADDR_W         = SEG_W + SECT_W + OFFS_W;
  localparam int          SECTOR_BYTES   = 256;
  localparam logic [17:0] UNLOCK_ADDR_0  = 18'h00001;
  localparam logic [17:0] UNLOCK_ADDR_1  = 18'h00002;
  localparam logic [17:0] UNLOCK_ADDR_2  = 18'h00003;

  // ****************************************
  // Buffer layout
  // ****************************************
  localparam int          CNT_W          = 10;
  localparam logic [9:0]  CNT_MAX        = 10'h3FF;
  localparam logic [9:0]  BUF_LAST_IDX   = 10'h205;
  localparam logic [9:0]  UNLOCK_IDX_0   = 10'h001;
  localparam logic [9:0]  UNLOCK_IDX_1   = 10'h003;
  localparam logic [9:0]  UNLOCK_IDX_2   = 10'h005;
  localparam logic [9:0]  DATA_FIRST_IDX = 10'h007;
  localparam logic [9:0]  TOGGLE_IDX     = 10'h001;
  localparam logic [7:0]  TOGGLE_CODE    = 8'hFF;
  localparam int          UNLOCK_STEPS   = 3;

  // ****************************************
  // Timing and buffering
  // ****************************************
  localparam int          CLK_MHZ        = 10;
  localparam int          STRAP_CYCLES   = 6;
  localparam int          PROG_TIME_US   = 10000;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          FIFO_W         = BYTE_W + 1;

  // ****************************************
  // State machines
  // ****************************************
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_BOOT  = 2'b01,
    ST_RUN   = 2'b11,
    ST_HOLD  = 2'b10
  } fcb_boot_e;

  typedef enum logic [2:0] {
    WR_IDLE  = 3'b000,
    WR_SETUP = 3'b001,
    WR_PULSE = 3'b011,
    WR_RECOV = 3'b010,
    WR_WAIT  = 3'b110
  } fcb_wr_e;
endpackage

// ==== hdl/fcb_fifo.sv ====
// Byte FIFO between the USB stream and the buffer parser
`timescale 1ns/1ps
`default_nettype none
module fcb_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         push_valid_in,
  input  wire logic [W-1:0] push_data_in,
  output logic              push_ready_out,
  output logic              pop_valid_out,
  output logic [W-1:0]      pop_data_out,
  input  wire logic         pop_ready_in
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [PW:0]  wr_reg;
  logic [PW:0]  wr_next;
  logic [PW:0]  rd_reg;
  logic [PW:0]  rd_next;
  logic         full;
  logic         empty;

  // Full when pointers differ only in the wrap bit
  assign empty          = (wr_reg == rd_reg);
  assign full           = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
  assign push_ready_out = !full;
  assign pop_valid_out  = !empty;
  assign pop_data_out   = mem_reg[rd_reg[PW-1:0]];

  // Pointer and storage update
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    if (push_valid_in && !full) begin
      mem_next[wr_reg[PW-1:0]] = push_data_in;
      wr_next                  = wr_reg + 1'b1;
    end
    if (pop_ready_in && !empty) begin
      rd_next = rd_reg + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // Storage registers
  always_ff @(posedge clk_in) begin
    mem_reg <= mem_next;
  end
endmodule
`default_nettype wire

// ==== hdl/fcb_flash_writer.sv ====
// Flash sector write sequencer: unlock codes, 256 data bytes, program wait
`timescale 1ns/1ps
`default_nettype none
module fcb_flash_writer #(
  parameter int PROG_CYCLES = 100000
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         start_in,
  input  wire logic [fcb_pkg::SEG_W-1:0]    segment_in,
  input  wire logic [fcb_pkg::SECT_W-1:0]   sector_in,
  input  wire logic [23:0]                  unlock_in,
  output logic      [fcb_pkg::OFFS_W-1:0]   rd_index_out,
  input  wire logic [fcb_pkg::BYTE_W-1:0]   rd_data_in,
  output logic      [fcb_pkg::ADDR_W-1:0]   flash_addr_out,
  output logic      [fcb_pkg::BYTE_W-1:0]   flash_data_out,
  output logic                              flash_we_n_out,
  output logic                              flash_ce_n_out,
  output logic                              busy_out,
  output logic                              done_out
);
  localparam logic [8:0] LAST_STEP = 9'(fcb_pkg::UNLOCK_STEPS + fcb_pkg::SECTOR_BYTES - 1);
  localparam logic [8:0] UNL_STEPS = 9'(fcb_pkg::UNLOCK_STEPS);

  fcb_pkg::fcb_wr_e                st_reg, st_next;
  logic [8:0]                      step_reg, step_next;
  logic [23:0]                     wait_reg, wait_next;
  logic [fcb_pkg::ADDR_W-1:0]      addr_reg, addr_next;
  logic [fcb_pkg::BYTE_W-1:0]      data_reg, data_next;
  logic                            we_n_reg, we_n_next;
  logic                            ce_n_reg, ce_n_next;
  logic                            done_reg, done_next;
  logic [17:0]                     unl_addr;
  logic [7:0]                      unl_data;

  assign rd_index_out   = 8'(step_reg - UNL_STEPS);
  assign busy_out       = (st_reg != fcb_pkg::WR_IDLE);
  assign flash_addr_out = addr_reg;
  assign flash_data_out = data_reg;
  assign flash_we_n_out = we_n_reg;
  assign flash_ce_n_out = ce_n_reg;
  assign done_out       = done_reg;

  // Unlock code and address for the first three steps
  always_comb begin
    unl_addr = fcb_pkg::UNLOCK_ADDR_0;
    unl_data = unlock_in[7:0];
    case (step_reg[1:0])
      2'h1: begin
        unl_addr = fcb_pkg::UNLOCK_ADDR_1;
        unl_data = unlock_in[15:8];
      end
      2'h2: begin
        unl_addr = fcb_pkg::UNLOCK_ADDR_2;
        unl_data = unlock_in[23:16];
      end
      default: begin
        unl_addr = fcb_pkg::UNLOCK_ADDR_0;
        unl_data = unlock_in[7:0];
      end
    endcase
  end

  // Write cycle sequencing
  always_comb begin
    st_next   = st_reg;
    step_next = step_reg;
    wait_next = wait_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    we_n_next = 1'b1;
    ce_n_next = ce_n_reg;
    done_next = 1'b0;
    case (st_reg)
      fcb_pkg::WR_IDLE: begin
        ce_n_next = 1'b1;
        if (start_in) begin
          step_next = '0;
          st_next   = fcb_pkg::WR_SETUP;
        end
      end
      fcb_pkg::WR_SETUP: begin
        ce_n_next = 1'b0;
        if (step_reg < UNL_STEPS) begin
          addr_next = {segment_in, unl_addr};
          data_next = unl_data;
        end else begin
          addr_next = {segment_in, sector_in, rd_index_out};
          data_next = rd_data_in;
        end
        st_next = fcb_pkg::WR_PULSE;
      end
      fcb_pkg::WR_PULSE: begin
        we_n_next = 1'b0;
        st_next   = fcb_pkg::WR_RECOV;
      end
      fcb_pkg::WR_RECOV: begin
        if (step_reg == LAST_STEP) begin
          ce_n_next = 1'b1;
          wait_next = '0;
          st_next   = fcb_pkg::WR_WAIT;
        end else begin
          step_next = step_reg + 1'b1;
          st_next   = fcb_pkg::WR_SETUP;
        end
      end
      fcb_pkg::WR_WAIT: begin
        wait_next = wait_reg + 1'b1;
        if (wait_reg >= 24'(PROG_CYCLES - 1)) begin
          done_next = 1'b1;
          st_next   = fcb_pkg::WR_IDLE;
        end
      end
      default: begin
        st_next = fcb_pkg::WR_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg   <= fcb_pkg::WR_IDLE;
      step_reg <= '0;
      wait_reg <= '0;
      addr_reg <= '0;
      data_reg <= '0;
      we_n_reg <= 1'b1;
      ce_n_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      step_reg <= step_next;
      wait_reg <= wait_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      we_n_reg <= we_n_next;
      ce_n_reg <= ce_n_next;
      done_reg <= done_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence unlock_first_s;
    (st_reg == fcb_pkg::WR_PULSE) && (step_reg == 9'h000);
  endsequence
  sequence unlock_code_s;
    flash_data_out == unlock_in[7:0] && flash_addr_out[17:0] == fcb_pkg::UNLOCK_ADDR_0;
  endsequence

  unlock_order_a: assert property (unlock_first_s |-> unlock_code_s ##4 flash_data_out == unlock_in[15:8])
    else $error("unlock codes out of order");
  one_pulse_a: assert property ($fell(flash_we_n_out) |-> !flash_ce_n_out ##1 flash_we_n_out)
    else $error("write strobe longer than one cycle");
endmodule
`default_nettype wire

// ==== hdl/fcb_boot_manager.sv ====
// Top of the flash configuration boot manager: selector, boot control, buffer parser
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - The flash is split in four equal image segments and two selector bits pick the active one.
// - The third selector bit picks configure mode or program mode.
// - In configure mode the logic device boots from the selected segment after power-up.
// - A cold boot in program mode holds the device in reset with the fail lamp lit, and programming is taken only while it is held so.
// - A reset-toggle command in program mode releases the device, and the lamp goes out once its boot succeeds.
// - A reset-toggle re-asserts the device reset only after a successful boot.
// - Each sector write fills one 256-byte flash sector and the sector address then steps by one.
// - A programming buffer is exactly 518 bytes and every even-index byte is ignored.
// - Bytes 1, 3 and 5 carry the three unlock codes, forwarded to the flash in that order.
// - The 256 data bytes sit at index 2*n+7 in image order.
// - A reset-toggle buffer is two bytes, the first ignored and the second equal to FF.
module fcb_boot_manager #(
  parameter int PROG_TIME_US = fcb_pkg::PROG_TIME_US,
  parameter int PROG_CYCLES  = PROG_TIME_US * fcb_pkg::CLK_MHZ
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic [fcb_pkg::SEL_W-1:0]     selector_in,
  input  wire logic                          boot_ok_in,
  input  wire logic [fcb_pkg::BYTE_W-1:0]    usb_data_in,
  input  wire logic                          usb_last_in,
  input  wire logic                          usb_valid_in,
  output logic                               usb_ready_out,
  output logic                               dev_reset_n_out,
  output logic                               fail_led_out,
  output logic      [fcb_pkg::SEG_W-1:0]     segment_out,
  output logic      [fcb_pkg::ADDR_W-1:0]    flash_addr_out,
  output logic      [fcb_pkg::BYTE_W-1:0]    flash_data_out,
  output logic                               flash_we_n_out,
  output logic                               flash_ce_n_out
);
  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0]                    rst_sync_reg;
  logic                          rst_n;
  logic [fcb_pkg::SEL_W-1:0]     sel_s1_reg, sel_s2_reg, sel_s3_reg;
  logic [fcb_pkg::SEL_W-1:0]     sel_reg, sel_next;
  logic                          ok_s1_reg, ok_s2_reg, ok_s3_reg;
  logic                          ok_reg, ok_next;

  // Reset released through two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin value taken once second and third stage agree
  always_comb begin
    sel_next = (sel_s2_reg == sel_s3_reg) ? sel_s3_reg : sel_reg;
    ok_next  = (ok_s2_reg == ok_s3_reg) ? ok_s3_reg : ok_reg;
  end

  // Synchroniser stages
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1_reg <= '0;
      sel_s2_reg <= '0;
      sel_s3_reg <= '0;
      sel_reg    <= '0;
      ok_s1_reg  <= 1'b0;
      ok_s2_reg  <= 1'b0;
      ok_s3_reg  <= 1'b0;
      ok_reg     <= 1'b0;
    end else begin
      sel_s1_reg <= selector_in;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      sel_reg    <= sel_next;
      ok_s1_reg  <= boot_ok_in;
      ok_s2_reg  <= ok_s1_reg;
      ok_s3_reg  <= ok_s2_reg;
      ok_reg     <= ok_next;
    end
  end

  // ****************************************
  // Input FIFO
  // ****************************************
  logic                          pop_valid;
  logic [fcb_pkg::FIFO_W-1:0]    pop_data;
  logic                          pop_ready;
  logic                          wr_busy;
  logic                          wr_done;
  logic                          wr_start_reg, wr_start_next;

  fcb_fifo #(
    .W     (fcb_pkg::FIFO_W),
    .DEPTH (fcb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n),
    .push_valid_in  (usb_valid_in),
    .push_data_in   ({usb_last_in, usb_data_in}),
    .push_ready_out (usb_ready_out),
    .pop_valid_out  (pop_valid),
    .pop_data_out   (pop_data),
    .pop_ready_in   (pop_ready)
  );

  // Parser stalls while a sector is being written
  assign pop_ready = !wr_busy && !wr_start_reg;

  // ****************************************
  // Buffer parser
  // ****************************************
  fcb_pkg::fcb_boot_e            st_reg, st_next;
  logic [fcb_pkg::CNT_W-1:0]     cnt_reg, cnt_next;
  logic [23:0]                   unl_reg, unl_next;
  logic [7:0]                    mem_reg [fcb_pkg::SECTOR_BYTES];
  logic [7:0]                    mem_next [fcb_pkg::SECTOR_BYTES];
  logic [fcb_pkg::SECT_W-1:0]    sect_reg, sect_next;
  logic                          take;
  logic                          last;
  logic [7:0]                    byte_v;
  logic                          prog_mode;
  logic                          accept;
  logic                          toggle_cmd;
  logic                          full_buf;
  logic [9:0]                    data_pos;
  logic [fcb_pkg::OFFS_W-1:0]    rd_index;

  assign take       = pop_valid && pop_ready;
  assign last       = pop_data[fcb_pkg::BYTE_W];
  assign byte_v     = pop_data[fcb_pkg::BYTE_W-1:0];
  assign prog_mode  = (sel_reg[fcb_pkg::MODE_BIT] == fcb_pkg::MODE_PROGRAM);
  assign accept     = prog_mode && (st_reg == fcb_pkg::ST_HOLD);
  assign full_buf   = take && last && (cnt_reg == fcb_pkg::BUF_LAST_IDX);
  assign toggle_cmd = take && last && (cnt_reg == fcb_pkg::TOGGLE_IDX)
                      && (byte_v == fcb_pkg::TOGGLE_CODE) && prog_mode;
  assign data_pos   = cnt_reg - fcb_pkg::DATA_FIRST_IDX;

  // Byte index, unlock capture and sector image store
  always_comb begin
    cnt_next      = cnt_reg;
    unl_next      = unl_reg;
    mem_next      = mem_reg;
    wr_start_next = 1'b0;
    if (take) begin
      if (last) begin
        cnt_next = '0;
      end else if (cnt_reg != fcb_pkg::CNT_MAX) begin
        cnt_next = cnt_reg + 1'b1;
      end
      // Even indices never stored
      if (cnt_reg[0]) begin
        case (cnt_reg)
          fcb_pkg::UNLOCK_IDX_0: unl_next[7:0]   = byte_v;
          fcb_pkg::UNLOCK_IDX_1: unl_next[15:8]  = byte_v;
          fcb_pkg::UNLOCK_IDX_2: unl_next[23:16] = byte_v;
          default: begin
            if (cnt_reg >= fcb_pkg::DATA_FIRST_IDX && cnt_reg <= fcb_pkg::BUF_LAST_IDX) begin
              mem_next[data_pos[8:1]] = byte_v;
            end
          end
        endcase
      end
      wr_start_next = full_buf && accept;
    end
  end

  // Parser registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg      <= '0;
      unl_reg      <= '0;
      wr_start_reg <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      unl_reg      <= unl_next;
      wr_start_reg <= wr_start_next;
    end
  end

  // Sector image storage
  always_ff @(posedge clk_in) begin
    mem_reg <= mem_next;
  end

  // ****************************************
  // Boot control
  // ****************************************
  logic [2:0] strap_reg, strap_next;
  logic       prog_prev_reg, prog_prev_next;

  always_comb begin
    st_next        = st_reg;
    strap_next     = strap_reg;
    sect_next      = sect_reg;
    prog_prev_next = prog_mode; // Mode bit one cycle back, for rise detection
    if (wr_done) begin
      sect_next = sect_reg + 1'b1;
    end
    case (st_reg)
      fcb_pkg::ST_START: begin
        // Wait for the selector synchroniser to settle
        if (strap_reg == 3'(fcb_pkg::STRAP_CYCLES - 1)) begin
          st_next = prog_mode ? fcb_pkg::ST_HOLD : fcb_pkg::ST_BOOT;
        end else begin
          strap_next = strap_reg + 1'b1;
        end
      end
      fcb_pkg::ST_BOOT: begin
        if (prog_mode && !prog_prev_reg) begin
          st_next = fcb_pkg::ST_HOLD;
        end else if (ok_reg) begin
          st_next = fcb_pkg::ST_RUN;
        end
      end
      fcb_pkg::ST_RUN: begin
        if (toggle_cmd) begin
          st_next = fcb_pkg::ST_HOLD;
        end else if (prog_mode && !prog_prev_reg) begin
          st_next = fcb_pkg::ST_HOLD;
        end
      end
      fcb_pkg::ST_HOLD: begin
        if (toggle_cmd && !wr_busy && !wr_start_reg) begin
          st_next = fcb_pkg::ST_BOOT;
        end
      end
      default: begin
        st_next = fcb_pkg::ST_START;
      end
    endcase
    if (st_next == fcb_pkg::ST_HOLD && st_reg != fcb_pkg::ST_HOLD) begin
      sect_next = '0;
    end
  end

  // Boot control registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= fcb_pkg::ST_START;
      strap_reg     <= '0;
      sect_reg      <= '0;
      prog_prev_reg <= 1'b1;
    end else begin
      st_reg        <= st_next;
      strap_reg     <= strap_next;
      sect_reg      <= sect_next;
      prog_prev_reg <= prog_prev_next;
    end
  end

  // Device reset held except while booting or running
  assign dev_reset_n_out = (st_reg == fcb_pkg::ST_BOOT) || (st_reg == fcb_pkg::ST_RUN);
  assign fail_led_out    = (st_reg != fcb_pkg::ST_RUN);
  assign segment_out     = sel_reg[fcb_pkg::SEG_W-1:0];

  // ****************************************
  // Flash writer
  // ****************************************
  fcb_flash_writer #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_writer (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n),
    .start_in       (wr_start_reg),
    .segment_in     (sel_reg[fcb_pkg::SEG_W-1:0]),
    .sector_in      (sect_reg),
    .unlock_in      (unl_reg),
    .rd_index_out   (rd_index),
    .rd_data_in     (mem_reg[rd_index]),
    .flash_addr_out (flash_addr_out),
    .flash_data_out (flash_data_out),
    .flash_we_n_out (flash_we_n_out),
    .flash_ce_n_out (flash_ce_n_out),
    .busy_out       (wr_busy),
    .done_out       (wr_done)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  hold_in_prog_a: assert property (st_reg == fcb_pkg::ST_HOLD |-> !dev_reset_n_out && fail_led_out)
    else $error("device not held in reset");
  toggle_release_a: assert property (st_reg == fcb_pkg::ST_HOLD && toggle_cmd && !wr_busy && !wr_start_reg
                                     |=> dev_reset_n_out && st_reg == fcb_pkg::ST_BOOT)
    else $error("toggle did not release device");
  reassert_ok_a: assert property (st_reg == fcb_pkg::ST_BOOT && toggle_cmd |=> dev_reset_n_out)
    else $error("reset re-asserted before boot success");
  sector_step_a: assert property (wr_done && st_reg == fcb_pkg::ST_HOLD |=> sect_reg == $past(sect_reg) + 1'b1)
    else $error("sector address did not advance");
  length_gate_a: assert property (wr_start_next |-> take && last && cnt_reg == fcb_pkg::BUF_LAST_IDX)
    else $error("write started on wrong length");
  write_mode_a: assert property ($rose(wr_busy) |-> prog_mode && st_reg == fcb_pkg::ST_HOLD)
    else $error("write outside program hold");
  toggle_form_a: assert property (toggle_cmd |-> cnt_reg == fcb_pkg::TOGGLE_IDX && byte_v == fcb_pkg::TOGGLE_CODE)
    else $error("toggle on malformed buffer");
  cfg_boot_a: assert property (st_reg == fcb_pkg::ST_START && st_next != fcb_pkg::ST_START && !prog_mode
                               |=> dev_reset_n_out [*2])
    else $error("configure mode did not boot");
  seg_addr_a: assert property (!flash_we_n_out |-> flash_addr_out[fcb_pkg::ADDR_W-1 -: fcb_pkg::SEG_W] == segment_out)
    else $error("flash write outside selected segment");
endmodule
`default_nettype wire

// ==== testbench/fcb_usb_host.sv ====
// USB host model streaming bulk buffers into the boot manager
`timescale 1ns/1ps
`default_nettype none
module fcb_usb_host (
  input  wire logic       clk_in,
  input  wire logic       ready_in,
  output logic [7:0]      data_out,
  output logic            last_out,
  output logic            valid_out
);
  // Idle stream at time zero
  initial begin
    data_out = 8'h00;
    last_out = 1'b0;
    valid_out = 1'b0;
  end
  // One buffer: unlock codes and data at odd slots, junk at even slots
  task automatic send(input int len, input logic [7:0] b1, input logic [7:0] tag);
    logic rdy;
    for (int i = 0; i < len; i++) begin
      #1;
      valid_out = 1'b1;
      last_out = (i == len - 1);
      data_out = (i == 1) ? b1 : (i == 3) ? 8'h55 : (i == 5) ? 8'hA0 :
                 i[0] ? 8'((i - 7) / 2) ^ tag : ~8'(i);
      // Ready only moves at an edge, so read it settled before waiting
      rdy = ready_in;
      @(posedge clk_in);
      while (!rdy) begin
        #1;
        rdy = ready_in;
        @(posedge clk_in);
      end
    end
    #1;
    valid_out = 1'b0;
    last_out = 1'b0;
    data_out = ~data_out;
  endtask
endmodule
`default_nettype wire

// ==== testbench/flash_config_boot_manager_tb.sv ====
// Self-checking bench of the flash configuration boot manager
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module flash_config_boot_manager_tb;
  localparam logic [1:0] SEG = 2'h2;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [2:0]  sel = 3'b110;
  logic        boot_ok = 1'b0;
  logic [7:0]  u_data, f_data;
  logic        u_last, u_valid, u_ready, rst_o, led, we_n, ce_n;
  logic [1:0]  seg_o;
  logic [19:0] f_addr;
  logic [19:0] wa[$];
  logic [7:0]  wd[$];
  logic [9:0]  sec = 10'h000;
  int          miscompares = 0;
  int          total_checks = 0;
  int          len_tbl[5] = '{518, 518, 517, 519, 2};
  logic [7:0]  b1_tbl[5] = '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'h00};
  int          nw_tbl[5] = '{259, 259, 0, 0, 0};
  always #50 clk_in = ~clk_in;
  fcb_usb_host host (.clk_in(clk_in), .ready_in(u_ready), .data_out(u_data), .last_out(u_last), .valid_out(u_valid));
  fcb_boot_manager #(.PROG_TIME_US(1)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .selector_in(sel),
    .boot_ok_in(boot_ok), .usb_data_in(u_data), .usb_last_in(u_last), .usb_valid_in(u_valid),
    .usb_ready_out(u_ready), .dev_reset_n_out(rst_o), .fail_led_out(led), .segment_out(seg_o),
    .flash_addr_out(f_addr), .flash_data_out(f_data), .flash_we_n_out(we_n), .flash_ce_n_out(ce_n));
  // Log every flash write strobe
  always @(negedge clk_in) if (we_n === 1'b0) begin
    wa.push_back(f_addr);
    wd.push_back(f_data);
  end
  // Send one buffer and compare the flash writes it caused
  task automatic run(input int len, input logic [7:0] b1, input int nw);
    logic [19:0] ea;
    logic [7:0]  ed, t;
    t = 8'h3C ^ sec[7:0];
    wa.delete();
    wd.delete();
    host.send(len, b1, t);
    repeat (900) @(posedge clk_in);
    `CHK(wa.size(), nw)
    for (int k = 0; k < wa.size(); k++) begin
      ea = (k == 0) ? {SEG, fcb_pkg::UNLOCK_ADDR_0} : (k == 1) ? {SEG, fcb_pkg::UNLOCK_ADDR_1} :
           (k == 2) ? {SEG, fcb_pkg::UNLOCK_ADDR_2} : {SEG, sec, 8'(k - 3)};
      ed = (k == 0) ? 8'hAA : (k == 1) ? 8'h55 : (k == 2) ? 8'hA0 : 8'(k - 3) ^ t;
      `CHK(wa[k], ea)
      `CHK(wd[k], ed)
    end
    if (nw != 0) sec = sec + 10'h001;
  endtask
  // Verdict and end of run
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (20) @(posedge clk_in);
    `CHK(rst_o, 1'b0)
    `CHK(led, 1'b1)
    `CHK(seg_o, SEG)
    for (int r = 0; r < 5; r++) begin
      run(len_tbl[r], b1_tbl[r], nw_tbl[r]);
      `CHK(rst_o, 1'b0)
    end
    run(2, 8'hFF, 0);
    `CHK(rst_o, 1'b1)
    run(518, 8'hAA, 0);
    run(2, 8'hFF, 0);
    `CHK(rst_o, 1'b1)
    #1 boot_ok = 1'b1;
    repeat (10) @(posedge clk_in);
    `CHK(led, 1'b0)
    run(2, 8'hFF, 0);
    `CHK(rst_o, 1'b0)
    `CHK(led, 1'b1)
    // Back-to-back buffers fill the FIFO while the first sector writes
    wa.delete();
    host.send(518, 8'hAA, 8'h11);
    host.send(518, 8'hAA, 8'h22);
    repeat (1800) @(posedge clk_in);
    `CHK(wa.size(), 518)
    `CHK(wa[3], ({SEG, 10'h000, 8'h00}))
    `CHK(wa[262], ({SEG, 10'h001, 8'h00}))
    `CHK(wd[262], 8'h22)
    // Cold boot in configure mode on segment 1
    #1 rst_n_in = 1'b0;
    sel = 3'b001;
    repeat (5) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (20) @(posedge clk_in);
    `CHK(rst_o, 1'b1)
    `CHK(seg_o, 2'h1)
    // Mode bit turned to program while booted holds the device again
    #1 sel = 3'b101;
    repeat (10) @(posedge clk_in);
    `CHK(rst_o, 1'b0)
    `CHK(led, 1'b1)
    complete_run();
  end
  // Watchdog against a hung stream
  initial begin
    repeat (30000) @(posedge clk_in);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
